// >>> ckirq_regs.svh
// constants for the carkit interrupt enable, status and latch registers
// assumes a ulpi register port that presents one byte address per access
`ifndef CKIRQ_REGS_SVH
`define CKIRQ_REGS_SVH
// register addresses
`define CKIRQ_ADDR_EN_WR 6'h1D
`define CKIRQ_ADDR_EN_SET 6'h1E
`define CKIRQ_ADDR_EN_CLR 6'h1F
`define CKIRQ_ADDR_STATUS 6'h20
`define CKIRQ_ADDR_LATCH 6'h21
// enable fields
`define CKIRQ_EN_RISE 0
`define CKIRQ_EN_FALL 1
`define CKIRQ_EN_COMP 2
`define CKIRQ_EN_RID 5
`define CKIRQ_EN_MASK 8'h27
// latch fields
`define CKIRQ_LAT_ID 0
`define CKIRQ_LAT_COMP 1
`define CKIRQ_LAT_RID 3
// reset value of every register
`define CKIRQ_RESET 8'h00
// id resistor code for a floating id pin
`define CKIRQ_RID_FLOAT 3'h5
// conversion time in ns and its cycle count at 4 ns per cycle
`define CKIRQ_CONV_NS 282000
`define CKIRQ_CLK_NS 4
`define CKIRQ_CONV_CYC (`CKIRQ_CONV_NS / `CKIRQ_CLK_NS)
`endif

// >>> ckirq_pkg.sv
// types shared by the carkit interrupt block
// assumes the constants header is included where numbers are needed
`default_nettype none
package ckirq_pkg;
  // detector levels seen by the block
  typedef struct packed {
    logic idOpen;
    logic compOut;
    logic measDone;
    logic [2:0] ridCode;
  } ckirq_det_s;
  // one register access from the ulpi register port
  typedef struct packed {
    logic wrStrobe;
    logic rdStrobe;
    logic [5:0] addr;
    logic [7:0] wrData;
  } ckirq_req_s;
endpackage : ckirq_pkg
`default_nettype wire

// >>> ckirq_carkit_irq.sv
// carkit interrupt enable, status and latch registers with alt_int output
// assumes detector levels and register strobes synchronous to ref_clk
// assumes the rxcmd builder samples altInt on every ref_clk edge
//
// What this block does
// - enable register has write, set, clear addresses
// - id open rise raises alt_int when enabled
// - id open fall raises alt_int when enabled
// - unused enable and dp bits read zero
// - resistor irq enable ored with vendor enable
// - status register shows live detector states
// - status bit 1 shows charger comparator
// - status bits 5:3 show resistor code
// - done bit set when conversion finishes
// - done cleared only by vendor result read
// - latch register clears when read
// - latch bit 0 on enabled id edges
// - latch bit 1 on enabled comparator change
// - latch bit 3 on enabled done rise
`timescale 1ns/1ns
`include "ckirq_regs.svh"
`default_nettype none
module ckirq_carkit_irq
(
  input wire logic ref_clk, // ulpi clock
  input wire logic rst_n, // synchronous power-on reset
  input wire ckirq_pkg::ckirq_req_s req, // register access
  input wire logic idOpenRaw, // id floating comparator
  input wire logic id_pullup_enable, // otg control pull-up
  input wire logic charger_comp_out, // charger data-detect comparator
  input wire logic charger_sink_enable, // comparator enable
  input wire logic convStart, // start an id resistor conversion
  input wire logic [2:0] convResult, // code from the converter
  input wire logic vendorRidIrqEn, // vendor register enable copy
  input wire logic vendorResultRead, // result read via vendor reg
  output logic [7:0] rdData, // read answer, one cycle later
  output logic altInt // alt_int level for rxcmd
);
  // ****************************************************
  // decode
  // ****************************************************
  logic [7:0] irqEn; // enable register
  logic [7:0] latch; // latch register
  // 17 bits: the 70500-cycle conversion overflows a 16-bit count
  logic [16:0] convCnt; // conversion timer
  logic converting; // conversion running
  logic measDone; // done flag
  logic [2:0] ridCode; // last conversion code
  logic prevOpen; // previous id open level
  logic prevComp; // previous comparator level
  logic prevDone; // previous done level
  // write decode; only one address can match in a cycle
  wire wrEn = req.wrStrobe && req.addr == `CKIRQ_ADDR_EN_WR;
  wire wrSet = req.wrStrobe && req.addr == `CKIRQ_ADDR_EN_SET;
  wire wrClr = req.wrStrobe && req.addr == `CKIRQ_ADDR_EN_CLR;
  wire rdLatch = req.rdStrobe && req.addr == `CKIRQ_ADDR_LATCH;
  // float only meaningful with the pull-up on
  wire idOpen = idOpenRaw && id_pullup_enable;
  // comparator forced low while its sink is disabled
  wire compOut = charger_comp_out && charger_sink_enable;
  wire ridEn = irqEn[`CKIRQ_EN_RID] || vendorRidIrqEn;
  // status: bit 2 and bit 7 stay zero
  wire [7:0] status = {1'b0, measDone, ridCode, 1'b0, compOut, idOpen};
  // detector edges against the last cycle's levels
  wire evRise = idOpen && !prevOpen && irqEn[`CKIRQ_EN_RISE];
  wire evFall = !idOpen && prevOpen && irqEn[`CKIRQ_EN_FALL];
  wire evComp = (compOut != prevComp) && irqEn[`CKIRQ_EN_COMP];
  wire evRid = measDone && !prevDone && ridEn;
  wire [7:0] evVec = {4'h0, evRid, 1'b0, evComp, evRise || evFall};
  // enable next value; the mask keeps unused bits at zero
  wire [7:0] next_irqEn = wrEn ? req.wrData & `CKIRQ_EN_MASK
                        : wrSet ? irqEn | (req.wrData & `CKIRQ_EN_MASK)
                        : wrClr ? irqEn & ~req.wrData
                        : irqEn;
  // read clears latch, but a same-cycle event survives
  wire [7:0] next_latch = (rdLatch ? 8'h00 : latch) | evVec;
  // read select: the enable reads back at all three of its addresses
  wire selEnable = req.addr >= `CKIRQ_ADDR_EN_WR
                   && req.addr <= `CKIRQ_ADDR_EN_CLR;
  wire selStatus = req.addr == `CKIRQ_ADDR_STATUS;
  wire selLatch = req.addr == `CKIRQ_ADDR_LATCH;
  // unmapped addresses answer zero
  wire [7:0] next_rdData = selEnable ? irqEn
                         : selStatus ? status
                         : selLatch ? latch
                         : 8'h00;
  // conversion ends on the last count of the timer
  wire convEnd = converting && convCnt == 17'(`CKIRQ_CONV_CYC - 1);

  // ****************************************************
  // registers
  // ****************************************************
  // register state and edge history
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      irqEn <= `CKIRQ_RESET;
      latch <= `CKIRQ_RESET;
      // history resets low, so a pin high at release reads as an edge
      prevOpen <= 1'b0;
      prevComp <= 1'b0;
      prevDone <= 1'b0;
      rdData <= `CKIRQ_RESET;
      altInt <= 1'b0;
    end
    else
    begin
      irqEn <= next_irqEn;
      latch <= next_latch;
      prevOpen <= idOpen;
      prevComp <= compOut;
      prevDone <= measDone;
      if (req.rdStrobe)
        rdData <= next_rdData;
      // alt_int follows any pending latch bit
      // registered so the rxcmd path sees a glitch-free level
      altInt <= |next_latch;
    end
  end

  // conversion timer; done set on finish, cleared by vendor read only
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      converting <= 1'b0;
      convCnt <= 17'h00000;
      measDone <= 1'b0;
      ridCode <= 3'h0;
    end
    else if (converting)
    begin
      // a start or vendor read while running is ignored
      if (convEnd)
      begin
        converting <= 1'b0;
        measDone <= 1'b1;
        ridCode <= convResult;
      end
      else
        convCnt <= convCnt + 17'h00001;
    end
    else
    begin
      if (convStart)
      begin
        converting <= 1'b1;
        convCnt <= 17'h00000;
      end
      // status reads never touch the done flag
      if (vendorResultRead)
        measDone <= 1'b0;
    end
  end

  // ****************************************************
  // assertions
  // ****************************************************
  // latch setting and clearing
  a_latch_clear: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    rdLatch && evVec == 8'h00 |=> latch == 8'h00)
    else $error("latch not cleared by read");
  a_latch_hold: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    !rdLatch |=> (latch & $past(latch)) == $past(latch))
    else $error("latch bit lost without read");
  a_rise_latch: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    evRise |=> latch[`CKIRQ_LAT_ID] && altInt)
    else $error("id rise not latched");
  a_fall_latch: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    evFall |=> latch[`CKIRQ_LAT_ID] && altInt)
    else $error("id fall not latched");
  a_comp_latch: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    evComp |=> latch[`CKIRQ_LAT_COMP])
    else $error("comparator change not latched");
  a_rid_latch: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    evRid |=> latch[`CKIRQ_LAT_RID])
    else $error("done rise not latched");
  a_unused_zero: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (irqEn & ~`CKIRQ_EN_MASK) == 8'h00 && latch[7:4] == 4'h0)
    else $error("unused bit set");
  // interrupt level toward the rxcmd path
  a_alt_level: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    altInt == (latch != 8'h00))
    else $error("alt_int disagrees with latch");
  // enable writes and reads
  a_enable_set: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    wrSet |=> (irqEn & $past(req.wrData) & `CKIRQ_EN_MASK)
              == ($past(req.wrData) & `CKIRQ_EN_MASK))
    else $error("set write lost bits");
  a_load_write: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    wrEn |=> irqEn == ($past(req.wrData) & `CKIRQ_EN_MASK))
    else $error("enable load wrong");
  a_clear_write: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    wrClr |=> (irqEn & $past(req.wrData)) == 8'h00)
    else $error("clear write left bits");
  a_enable_read: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    req.rdStrobe && selEnable |=> rdData == $past(irqEn))
    else $error("enable read wrong");
  // status and latch reads
  a_status_read: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    req.rdStrobe && selStatus |=> rdData == $past(status))
    else $error("status read wrong");
  a_latch_read: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    rdLatch |=> rdData == $past(latch))
    else $error("latch read wrong");
  a_reserved_read: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    rdData[7] == 1'b0)
    else $error("reserved read bit set");
  // conversion and done flag
  a_done_set: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    convEnd |=> measDone)
    else $error("done not set at conversion end");
  a_code_capture: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    convEnd |=> ridCode == $past(convResult))
    else $error("resistor code not captured");
  a_done_hold: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    measDone && !vendorResultRead |=> measDone)
    else $error("done cleared without vendor read");
  a_done_clear: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    vendorResultRead && !converting |=> !measDone)
    else $error("done not cleared by vendor read");
  // reset
  a_reset_zero: assert property (
    @(posedge ref_clk)
    !rst_n |=> irqEn == 8'h00 && latch == 8'h00
               && !altInt && rdData == 8'h00)
    else $error("register not zero after reset");
endmodule : ckirq_carkit_irq
`default_nettype wire

// >>> ckirq_link_model.sv
// link controller side: ulpi immediate register reads and writes
// assumes rdData is registered one cycle after the read strobe edge
`timescale 1ns/1ns
`default_nettype none
module ckirq_link_model
(
  input wire logic ref_clk,
  input wire logic [7:0] rdData,
  output var ckirq_pkg::ckirq_req_s req
);
  // idle bus: no strobe raised
  initial req = '0;
  // one write byte, strobe for a single edge
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    req <= {1'b1, 1'b0, a, d};
    @(posedge ref_clk);
    req <= '0;
  endtask : wr
  // one read byte, answer taken once the register has landed
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    req <= {1'b0, 1'b1, a, 8'h00};
    @(posedge ref_clk);
    req <= '0;
    #1 d = rdData;
  endtask : rd
endmodule : ckirq_link_model
`default_nettype wire

// >>> ckirq_tb.sv
// self-checking bench for the carkit interrupt registers
// assumes the link model drives all register traffic
`timescale 1ns/1ns
`include "ckirq_regs.svh"
`default_nettype none
module tb;
  typedef struct packed {logic [5:0] a; logic [7:0] d; logic [7:0] e;}
    ckirq_row_s;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic idOpen = 1'b0, pull = 1'b0, comp = 1'b0, sink = 1'b0;
  logic conv = 1'b0, ven = 1'b0, vrd = 1'b0, altInt;
  logic [2:0] res = 3'h0;
  logic [7:0] rdData;
  ckirq_pkg::ckirq_req_s req;
  int n_mismatch = 0, n_checks = 0, cyc = 0;
  // enable writes: address, data, value read back at all three
  ckirq_row_s rows [5] = '{'{6'h1D, 8'hFF, 8'h27}, '{6'h1F, 8'h05, 8'h22},
    '{6'h1E, 8'h18, 8'h22}, '{6'h1E, 8'h01, 8'h23}, '{6'h1D, 8'h00, 8'h00}};
  always #2 ref_clk = ~ref_clk;
  ckirq_carkit_irq ckirq_carkit_irq_inst (.ref_clk(ref_clk), .rst_n(rst_n),
    .req(req), .idOpenRaw(idOpen), .id_pullup_enable(pull),
    .charger_comp_out(comp), .charger_sink_enable(sink), .convStart(conv),
    .convResult(res), .vendorRidIrqEn(ven), .vendorResultRead(vrd),
    .rdData(rdData), .altInt(altInt));
  ckirq_link_model ckirq_link_model_inst (.ref_clk(ref_clk),
    .rdData(rdData), .req(req));
  task automatic summarize();
    if (n_mismatch == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  task automatic chk(input string n, input logic [7:0] e, logic [7:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic rdchk(input string n, logic [5:0] a, logic [7:0] e);
    logic [7:0] d;
    ckirq_link_model_inst.rd(a, d);
    chk(n, e, d);
  endtask : rdchk
  // hang guard: run needs about 70600 cycles
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 80000)
    begin
      n_mismatch++;
      summarize();
    end
  end
  initial
  begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    rdchk("enable", `CKIRQ_ADDR_EN_WR, `CKIRQ_RESET);
    rdchk("status", `CKIRQ_ADDR_STATUS, `CKIRQ_RESET);
    rdchk("unmapped", 6'h3F, 8'h00);
    foreach (rows[i])
    begin
      ckirq_link_model_inst.wr(rows[i].a, rows[i].d);
      for (int j = 0; j < 3; j++)
        rdchk("enable", 6'h1D + 6'(j), rows[i].e);
    end
    // id float rise then fall with pull-up on
    ckirq_link_model_inst.wr(`CKIRQ_ADDR_EN_WR, 8'h03);
    {pull, idOpen} <= 2'h3;
    repeat (3) @(posedge ref_clk);
    #1 chk("altInt", 8'h01, {7'h0, altInt});
    rdchk("status", `CKIRQ_ADDR_STATUS, 8'h01);
    rdchk("latch", `CKIRQ_ADDR_LATCH, 8'h01);
    chk("altInt", 8'h00, {7'h0, altInt});
    rdchk("latch", `CKIRQ_ADDR_LATCH, 8'h00);
    idOpen <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rdchk("latch", `CKIRQ_ADDR_LATCH, 8'h01);
    // comparator change in both directions
    ckirq_link_model_inst.wr(`CKIRQ_ADDR_EN_WR, 8'h04);
    {sink, comp} <= 2'h3;
    repeat (3) @(posedge ref_clk);
    rdchk("status", `CKIRQ_ADDR_STATUS, 8'h02);
    rdchk("latch", `CKIRQ_ADDR_LATCH, 8'h02);
    comp <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rdchk("latch", `CKIRQ_ADDR_LATCH, 8'h02);
    // resistor conversion via the vendor enable only
    ckirq_link_model_inst.wr(`CKIRQ_ADDR_EN_WR, 8'h00);
    {ven, conv, res} <= {2'h3, `CKIRQ_RID_FLOAT};
    @(posedge ref_clk);
    conv <= 1'b0;
    repeat (70000) @(posedge ref_clk);
    #1 chk("early", 8'h00, {7'h0, altInt});
    for (int k = 0; k < 1000 && altInt !== 1'b1; k++)
      @(posedge ref_clk);
    rdchk("status", `CKIRQ_ADDR_STATUS, 8'h68);
    rdchk("latch", `CKIRQ_ADDR_LATCH, 8'h08);
    rdchk("status", `CKIRQ_ADDR_STATUS, 8'h68);
    vrd <= 1'b1;
    @(posedge ref_clk);
    vrd <= 1'b0;
    rdchk("status", `CKIRQ_ADDR_STATUS, 8'h28);
    // mid-run reset with a pending latch bit clears everything
    ckirq_link_model_inst.wr(`CKIRQ_ADDR_EN_WR, 8'h27);
    comp <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 chk("altInt", 8'h01, {7'h0, altInt});
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    #1 chk("altInt", 8'h00, {7'h0, altInt});
    rdchk("enable", `CKIRQ_ADDR_EN_SET, `CKIRQ_RESET);
    rdchk("latch", `CKIRQ_ADDR_LATCH, `CKIRQ_RESET);
    summarize();
  end
endmodule : tb
`default_nettype wire
